// ===== logic/sss_pkg.sv
// Constants, register map and carrier types of the supply supervisor core.
package sss_pkg;
   localparam int NUM_DET = 6;
   localparam int NUM_OUT = 8;
   localparam int NUM_GPI = 4;
   localparam int NUM_WD = 2;
   localparam int NUM_ADC = NUM_DET + 2;
   localparam int ADC_BITS = 10;
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 12500;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam longint SCAN_NS = 64'd200000000;
   localparam int SLOT_TICKS = int'(SCAN_NS / NUM_ADC / TICK_NS);
   localparam longint DLY_NS [8] = '{64'd25000, 64'd1562500, 64'd6250000, 64'd25000000,
      64'd50000000, 64'd200000000, 64'd400000000, 64'd1600000000};
   localparam longint WD_NS [8] = '{64'd6250000, 64'd25000000, 64'd100000000,
      64'd400000000, 64'd1600000000, 64'd6400000000, 64'd25600000000, 64'd102400000000};
   ////////////////////////////////////////////////////////////
   // Register byte addresses.
   localparam logic [7:0] A_OUT = 8'h00;
   localparam logic [7:0] A_GLOBAL = 8'h40;
   localparam logic [7:0] A_STATUS = 8'h41;
   localparam logic [7:0] A_WD = 8'h42;
   localparam logic [7:0] A_DET_PRI = 8'h46;
   localparam logic [7:0] A_DET_SEC = 8'h47;
   localparam logic [7:0] A_FAULT = 8'h48;
   localparam logic [7:0] A_ADC = 8'h50;
   localparam logic [7:0] A_ADC_LAST = 8'h5f;
   localparam logic [7:0] A_DET = 8'h60;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int OUT_REGS = 5;
   ////////////////////////////////////////////////////////////
   // Offsets inside an output block and field positions.
   localparam logic [2:0] O_PRI = 3'h0;
   localparam logic [2:0] O_SEC = 3'h1;
   localparam logic [2:0] O_SRC = 3'h2;
   localparam logic [2:0] O_PO = 3'h3;
   localparam logic [2:0] O_CTL = 3'h4;
   localparam int SRC_GPI = 0;
   localparam int SRC_WD = 4;
   localparam int SRC_MR = 6;
   localparam int CTL_DLY = 0;
   localparam int CTL_POL = 3;
   localparam int CTL_MST = 4;
   localparam int G_REF_EXT = 0;
   localparam int G_MHOLD = 1;
   localparam int G_GPI_LOW = 4;
   localparam int W_NORM = 0;
   localparam int W_INIT = 3;
   localparam int W_INIT_EN = 6;
   localparam int W_EN = 7;
   localparam int C_PO = 0;
   localparam int C_GPI = 3;
   localparam int C_PO_EN = 6;
   localparam int C_GPI_EN = 7;
   localparam int F_UV = 0;
   localparam int F_OV = 1;
   localparam int F_MR = 2;
   localparam int F_GPI = 3;
   localparam int F_WD = 4;
   localparam int F_PO = 5;

   typedef struct packed {
      logic neg;
      logic secOver;
      logic highRange;
      logic [7:0] secCode;
      logic [7:0] priCode;
   } det_cfg_t;

   function automatic logic [23:0] ticksOf(input longint ns);
      return 24'(ns / TICK_NS);
   endfunction : ticksOf
endpackage : sss_pkg

// ===== logic/sss_watchdog.sv
// One watchdog timer with a selectable clear source and two timeout periods.
`timescale 1ns/1ps
module sss_watchdog (
   input logic core_clk,
   input logic rstn,
   input logic tick,
   input logic run,
   input logic [7:0] ctrl,
   input logic [7:0] clrSrc,
   input logic [3:0] gpiAct,
   input logic [7:0] poAct,
   output logic timeout
);
   logic [23:0] cnt_q;
   logic useInit_q;
   logic srcPrev_q;
   logic timeout_q;

   wire gpiEn = clrSrc[sss_pkg::C_GPI_EN];
   wire poEn = clrSrc[sss_pkg::C_PO_EN];
   wire gpiBit = gpiAct[clrSrc[sss_pkg::C_GPI +: 2]];
   wire poBit = poAct[clrSrc[sss_pkg::C_PO +: 3]];
   // With both sources on, the joint level is watched so a toggle of one clears only while the other is active.
   wire src = (gpiBit | ~gpiEn) & (poBit | ~poEn); // [RQ14]
   wire clrEv = (gpiEn | poEn) && (src != srcPrev_q); // [RQ24]
   wire [2:0] sel = useInit_q ? ctrl[sss_pkg::W_INIT +: 3] : ctrl[sss_pkg::W_NORM +: 3];
   wire [23:0] limit = sss_pkg::ticksOf(sss_pkg::WD_NS[sel]); // [RQ15] [RQ22]
   wire active = run && ctrl[sss_pkg::W_EN];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 24'h0;
         useInit_q <= 1'b0;
         srcPrev_q <= 1'b0;
         timeout_q <= 1'b0;
      end else begin
         srcPrev_q <= src;
         timeout_q <= 1'b0;
         if (!active) begin
            cnt_q <= 24'h0;
            useInit_q <= ctrl[sss_pkg::W_INIT_EN];
         end else if (clrEv) begin
            cnt_q <= 24'h0; // [RQ24]
            useInit_q <= 1'b0;
         end else if (tick) begin
            if (cnt_q + 24'h1 >= limit) begin
               cnt_q <= 24'h0;
               useInit_q <= 1'b0;
               timeout_q <= 1'b1; // [RQ13]
            end else begin
               cnt_q <= cnt_q + 24'h1;
            end
         end
      end
   end

   assign timeout = timeout_q;
endmodule : sss_watchdog

// ===== logic/sss_supervisor.sv
// Supply supervisor core: detector config, outputs, faults, watchdogs and scan.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Notes on behaviour
// RQ1: Each detector has primary and secondary thresholds.
// RQ2: High-voltage input threshold has two ranges.
// RQ3: Bipolar input threshold: two ranges, selectable polarity.
// RQ4: Positive inputs threshold has two ranges.
// RQ5: One converter scans all channels every 200ms.
// RQ6: Results readable at 50h through 5Fh.
// RQ7: Results never influence outputs or sequencing.
// RQ8: Host reaches memories, config, results and faults.
// RQ9: Outputs assert on configured mix of sources.
// RQ10: Outputs deassert after a programmable delay.
// RQ11: Fault register records each assertion cause.
// RQ12: Each output has a selectable active level.
// RQ13: Two watchdogs assert their selected outputs.
// RQ14: Watchdog clears from input, output, or both.
// RQ15: Separate initial and normal watchdog timeouts.
// RQ16: Outputs valid only above the lockout level.
// RQ17: Output one sinks weakly below lockout.
// RQ18: Reference select between internal and external.
// RQ19: Manual reset forces outputs; delay after release.
// RQ20: Margin holds or forces outputs, beats reset.
// RQ21: Eight selectable output deassertion delays.
// RQ22: Eight selectable watchdog timeout values.
// RQ23: A returning condition restarts the delay count.
// RQ24: Each clear source transition restarts watchdog; with both sources on, only a change of their joint level does.
// RQ25: Fault bits stay set until host clears.
////////////////////////////////////////////////////////////
module sss_supervisor #(
   parameter int TickCycles = sss_pkg::TICK_CYC,
   parameter int SlotTicks = sss_pkg::SLOT_TICKS
) (
   input logic core_clk,
   input logic rstn,
   input logic [7:0] regAddr,
   input logic [7:0] regWrData,
   input logic regWr,
   input logic regRd,
   output logic [7:0] regRdData,
   input logic [5:0] detPriTrip,
   input logic [5:0] detSecTrip,
   input logic [3:0] gpiPin,
   input logic manualResetN,
   input logic marginN,
   input logic uvloOk,
   input logic adcDone,
   input logic [9:0] adcData,
   output sss_pkg::det_cfg_t [5:0] detCfg,
   output logic refExternal,
   output logic [2:0] adcChan,
   output logic adcStart,
   output logic [7:0] poLevel,
   output logic [7:0] poDriveEn,
   output logic outOneWeakSink
);
   localparam int NOUT = sss_pkg::NUM_OUT;
   localparam int NDET = sss_pkg::NUM_DET;
   localparam int NSYNC = 30;

   ////////////////////////////////////////////////////////////
   // Two-stage synchronisers on every pin input.
   logic [NSYNC-1:0] syncA_q;
   logic [NSYNC-1:0] syncB_q;
   wire [NSYNC-1:0] rawIn = {adcData, adcDone, uvloOk, marginN, manualResetN, gpiPin,
      detSecTrip, detPriTrip};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else begin
         syncA_q <= rawIn;
         syncB_q <= syncA_q;
      end
   end

   wire [5:0] detPri = syncB_q[5:0];
   wire [5:0] detSec = syncB_q[11:6];
   wire [3:0] gpiSync = syncB_q[15:12];
   wire mrAct = ~syncB_q[16];
   wire marginAct = ~syncB_q[17];
   wire supplyOk = syncB_q[18];
   wire doneSync = syncB_q[19];
   wire [9:0] dataSync = syncB_q[29:20];

   ////////////////////////////////////////////////////////////
   // Time base: one tick every TickCycles core clocks.
   logic [23:0] tickCnt_q;
   wire tick = tickCnt_q == 24'(TickCycles - 1);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tickCnt_q <= 24'h0;
      end else begin
         tickCnt_q <= tick ? 24'h0 : tickCnt_q + 24'h1;
      end
   end

   ////////////////////////////////////////////////////////////
   // Global control and shared decode.
   logic [7:0] global_q;
   logic [7:0] wdReg_q [4];
   wire globalSel = regAddr == sss_pkg::A_GLOBAL;
   wire [3:0] gpiAct = gpiSync ^ global_q[sss_pkg::G_GPI_LOW +: 4];
   wire marginHold = global_q[sss_pkg::G_MHOLD];
   wire wdSel = regAddr >= sss_pkg::A_WD && regAddr < sss_pkg::A_WD + 8'h4;
   wire [1:0] wdIdx = 2'(regAddr - sss_pkg::A_WD);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         global_q <= sss_pkg::RST_BYTE;
         for (int i = 0; i < 4; i++) begin
            wdReg_q[i] <= sss_pkg::RST_BYTE;
         end
      end else begin
         if (regWr && globalSel) begin
            global_q <= regWrData;
         end
         if (regWr && wdSel) begin
            wdReg_q[wdIdx] <= regWrData;
         end
      end
   end

   assign refExternal = global_q[sss_pkg::G_REF_EXT]; // [RQ18]

   ////////////////////////////////////////////////////////////
   // Detector threshold configuration handed to the comparators.
   logic [5:0] secOver;
   logic [7:0] detRd [NDET];

   for (genvar d = 0; d < NDET; d++) begin : g_det
      sss_pkg::det_cfg_t cfg_q;
      wire [7:0] base = 8'(sss_pkg::A_DET + 3 * d);
      wire priSel = regAddr == base;
      wire secSel = regAddr == base + 8'h1;
      wire ctlSel = regAddr == base + 8'h2;

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            cfg_q <= '0;
         end else if (regWr) begin
            if (priSel) begin
               cfg_q.priCode <= regWrData; // [RQ1] [RQ2] [RQ3] [RQ4]
            end
            if (secSel) begin
               cfg_q.secCode <= regWrData; // [RQ1]
            end
            if (ctlSel) begin
               {cfg_q.neg, cfg_q.secOver, cfg_q.highRange} <= regWrData[2:0]; // [RQ3]
            end
         end
      end

      assign detCfg[d] = cfg_q;
      assign secOver[d] = cfg_q.secOver;
      assign detRd[d] = priSel ? cfg_q.priCode : secSel ? cfg_q.secCode :
         ctlSel ? {5'h0, cfg_q.neg, cfg_q.secOver, cfg_q.highRange} : 8'h00;
   end

   ////////////////////////////////////////////////////////////
   // Watchdogs.
   logic [1:0] wdTo;
   logic [7:0] poAct;

   for (genvar j = 0; j < sss_pkg::NUM_WD; j++) begin : g_wd
      sss_watchdog u_wd (
         .core_clk(core_clk),
         .rstn(rstn),
         .tick(tick),
         .run(supplyOk),
         .ctrl(wdReg_q[2 * j]),
         .clrSrc(wdReg_q[2 * j + 1]),
         .gpiAct(gpiAct),
         .poAct(poAct),
         .timeout(wdTo[j])
      );
   end

   ////////////////////////////////////////////////////////////
   // Programmable outputs with delay, polarity and fault logging.
   logic [7:0] outRd [NOUT];
   logic [7:0] levelQ;
   logic [7:0] driveQ;

   for (genvar k = 0; k < NOUT; k++) begin : g_out
      logic [7:0] ob_q [sss_pkg::OUT_REGS];
      logic asserted_q;
      logic [23:0] dlyCnt_q;
      logic [5:0] fault_q;
      logic level_q;
      logic drive_q;
      wire [2:0] offs = regAddr[2:0];
      wire cfgSel = regAddr[7:3] == 5'(k) && offs < 3'(sss_pkg::OUT_REGS);
      wire faultSel = regAddr == 8'(sss_pkg::A_FAULT + k);
      wire [7:0] src = ob_q[sss_pkg::O_SRC];
      wire [7:0] ctl = ob_q[sss_pkg::O_CTL];
      wire [7:0] others = ~8'(1 << k);
      wire [5:0] secHit = detSec & ob_q[sss_pkg::O_SEC][5:0];
      logic [5:0] cause;
      always_comb begin
         cause = 6'h00;
         cause[sss_pkg::F_UV] = |(detPri & ob_q[sss_pkg::O_PRI][5:0]) | |(secHit & ~secOver);
         cause[sss_pkg::F_OV] = |(secHit & secOver);
         cause[sss_pkg::F_MR] = mrAct & src[sss_pkg::SRC_MR]; // [RQ19]
         cause[sss_pkg::F_GPI] = |(gpiAct & src[sss_pkg::SRC_GPI +: 4]);
         cause[sss_pkg::F_WD] = |(wdTo & src[sss_pkg::SRC_WD +: 2]); // [RQ13]
         cause[sss_pkg::F_PO] = |(poAct & ob_q[sss_pkg::O_PO] & others);
      end
      wire cond = |cause; // [RQ9]
      wire [23:0] dlyLimit = sss_pkg::ticksOf(sss_pkg::DLY_NS[ctl[sss_pkg::CTL_DLY +: 3]]);
      wire dlyDone = dlyCnt_q + 24'h1 >= dlyLimit; // [RQ21]
      wire [5:0] faultClr = (regWr && faultSel) ? regWrData[5:0] : 6'h00;
      wire [5:0] faultSet = (supplyOk && !marginAct) ? cause : 6'h00;
      wire activeHigh = ctl[sss_pkg::CTL_POL];

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            for (int i = 0; i < sss_pkg::OUT_REGS; i++) begin
               ob_q[i] <= sss_pkg::RST_BYTE;
            end
         end else if (regWr && cfgSel) begin
            ob_q[offs] <= regWrData;
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            asserted_q <= 1'b0;
            dlyCnt_q <= 24'h0;
         end else if (!supplyOk) begin
            asserted_q <= 1'b0; // [RQ16]
            dlyCnt_q <= 24'h0;
         end else if (marginAct) begin
            if (!marginHold) begin
               asserted_q <= ctl[sss_pkg::CTL_MST]; // [RQ20]
            end
         end else if (cond) begin
            asserted_q <= 1'b1;
            dlyCnt_q <= 24'h0; // [RQ23]
         end else if (asserted_q && tick) begin
            if (dlyDone) begin
               asserted_q <= 1'b0; // [RQ10] [RQ19]
               dlyCnt_q <= 24'h0;
            end else begin
               dlyCnt_q <= dlyCnt_q + 24'h1;
            end
         end
      end

      // A new cause in the clearing cycle survives the clear.
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            fault_q <= 6'h00;
         end else begin
            fault_q <= faultSet | (fault_q & ~faultClr); // [RQ11] [RQ25]
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            level_q <= 1'b0;
            drive_q <= 1'b0;
         end else begin
            level_q <= supplyOk && (activeHigh ? asserted_q : !asserted_q); // [RQ12] [RQ17]
            drive_q <= supplyOk; // [RQ16]
         end
      end

      assign poAct[k] = asserted_q;
      assign levelQ[k] = level_q;
      assign driveQ[k] = drive_q;
      assign outRd[k] = cfgSel ? ob_q[offs] : faultSel ? {2'h0, fault_q} : 8'h00;
   end

   logic weakSink_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         weakSink_q <= 1'b1;
      end else begin
         weakSink_q <= !supplyOk; // [RQ17]
      end
   end

   assign poLevel = levelQ;
   assign poDriveEn = driveQ;
   assign outOneWeakSink = weakSink_q;

   ////////////////////////////////////////////////////////////
   // Converter scan. Results feed only the register file, never the outputs.
   logic [23:0] slotCnt_q;
   logic [2:0] chan_q;
   logic start_q;
   logic donePrev_q;
   logic [9:0] adcRes_q [sss_pkg::NUM_ADC];
   wire slotEnd = tick && slotCnt_q == 24'(SlotTicks - 1);
   wire doneRise = doneSync && !donePrev_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         slotCnt_q <= 24'h0;
         chan_q <= 3'h0;
         start_q <= 1'b0;
         donePrev_q <= 1'b0;
      end else begin
         donePrev_q <= doneSync;
         start_q <= slotEnd; // [RQ5]
         if (slotEnd) begin
            slotCnt_q <= 24'h0;
            chan_q <= chan_q + 3'h1;
         end else if (tick) begin
            slotCnt_q <= slotCnt_q + 24'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < sss_pkg::NUM_ADC; i++) begin
            adcRes_q[i] <= 10'h000;
         end
      end else if (doneRise) begin
         adcRes_q[chan_q] <= dataSync; // [RQ5] [RQ7]
      end
   end

   assign adcChan = chan_q;
   assign adcStart = start_q;

   ////////////////////////////////////////////////////////////
   // Register read path; unmapped addresses read zero.
   wire adcSel = regAddr >= sss_pkg::A_ADC && regAddr <= sss_pkg::A_ADC_LAST;
   wire [9:0] adcWord = adcRes_q[regAddr[3:1]];
   wire [7:0] adcByte = regAddr[0] ? {adcWord[1:0], 6'h00} : adcWord[9:2]; // [RQ6]
   logic [7:0] rdMux;
   logic [7:0] regRdData_q;

   always_comb begin
      rdMux = 8'h00;
      for (int i = 0; i < NOUT; i++) begin
         rdMux = rdMux | outRd[i]; // [RQ8] [RQ11]
      end
      for (int i = 0; i < NDET; i++) begin
         rdMux = rdMux | detRd[i]; // [RQ8]
      end
      if (globalSel) begin
         rdMux = global_q;
      end
      if (regAddr == sss_pkg::A_STATUS) begin
         rdMux = poAct;
      end
      if (wdSel) begin
         rdMux = wdReg_q[wdIdx];
      end
      if (regAddr == sss_pkg::A_DET_PRI) begin
         rdMux = {2'h0, detPri};
      end
      if (regAddr == sss_pkg::A_DET_SEC) begin
         rdMux = {2'h0, detSec};
      end
      if (adcSel) begin
         rdMux = adcByte; // [RQ6]
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         regRdData_q <= 8'h00;
      end else begin
         regRdData_q <= regRd ? rdMux : 8'h00;
      end
   end

   assign regRdData = regRdData_q;
endmodule : sss_supervisor

// ===== tb/sss_supervisor_checker.sv
// Concurrent checks on the ports of the supervisor core.
`timescale 1ns/1ps
module sss_supervisor_checker (
   input logic core_clk,
   input logic rstn,
   input logic [7:0] regAddr,
   input logic [7:0] regWrData,
   input logic regWr,
   input logic regRd,
   input logic [7:0] regRdData,
   input logic uvloOk,
   input logic refExternal,
   input logic [2:0] adcChan,
   input logic adcStart,
   input logic [7:0] poLevel,
   input logic [7:0] poDriveEn,
   input logic outOneWeakSink
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////
   a_rd_idle: assert property (!regRd |=> regRdData == 8'h00)
      else $error("read data not zero outside a read");
   a_rd_unmapped: assert property (regRd && regAddr >= 8'h80 |=> regRdData == 8'h00)
      else $error("unmapped read returned data");
   a_ref_select: assert property (regWr && regAddr == sss_pkg::A_GLOBAL
      |=> refExternal == $past(regWrData[0]))
      else $error("reference select did not follow write");
   // Six cycles cover the input synchroniser and the output register.
   a_dark_outputs: assert property (!uvloOk [*6] |-> poLevel == 8'h00 && outOneWeakSink)
      else $error("outputs not parked below lockout");
   a_sink_vs_drive: assert property (poDriveEn == {8{!outOneWeakSink}})
      else $error("weak sink and drive enable overlap");
   a_supply_up: assert property (uvloOk [*6] |-> !outOneWeakSink)
      else $error("weak sink still on above lockout");
   a_start_gap: assert property (adcStart |=> (!adcStart) [*8])
      else $error("converter starts too close together");
   a_chan_step: assert property (adcStart |-> adcChan == $past(adcChan) + 3'h1)
      else $error("channel did not advance by one");
   a_chan_hold: assert property (!adcStart |-> $stable(adcChan))
      else $error("channel moved without a start");
endmodule : sss_supervisor_checker

// ===== tb/sss_adc_model.sv
// Behavioural converter that answers each start request of the scan.
`timescale 1ns/1ps
module sss_adc_model (
   input logic core_clk,
   input logic rstn,
   input logic adcStart,
   input logic [2:0] adcChan,
   output logic adcDone,
   output logic [9:0] adcData
);
   logic [3:0] wait_q;
   // Odd channels answer slowly so both short and long conversions are seen.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         adcDone <= 1'b0;
         adcData <= 10'h000;
         wait_q <= 4'h0;
      end else if (adcStart) begin
         adcDone <= 1'b0;
         adcData <= {~adcChan, adcChan, 4'h5};
         wait_q <= adcChan[0] ? 4'hc : 4'h3;
      end else if (wait_q == 4'h1) begin
         adcDone <= 1'b1;
         wait_q <= 4'h0;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end
   end
endmodule : sss_adc_model

// ===== tb/sss_supervisor_tb_top.sv
// Self-checking bench for the supply supervisor core.
`timescale 1ns/1ps
module sss_supervisor_tb_top;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic [5:0] detPriTrip = 6'h00;
   logic [5:0] detSecTrip = 6'h00;
   logic [3:0] gpiPin = 4'h0;
   logic manualResetN = 1'b1;
   logic marginN = 1'b1;
   logic uvloOk = 1'b0;
   logic adcDone;
   logic [9:0] adcData;
   sss_pkg::det_cfg_t [5:0] detCfg;
   logic refExternal;
   logic [2:0] adcChan;
   logic adcStart;
   logic [7:0] poLevel;
   logic [7:0] poDriveEn;
   logic outOneWeakSink;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;

   always #5 core_clk = ~core_clk;

   // Short tick and slot keep delays and the scan within a few hundred cycles.
   sss_supervisor #(.TickCycles(4), .SlotTicks(5)) dut (.core_clk(core_clk), .rstn(rstn),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .detPriTrip(detPriTrip), .detSecTrip(detSecTrip),
      .gpiPin(gpiPin), .manualResetN(manualResetN), .marginN(marginN), .uvloOk(uvloOk),
      .adcDone(adcDone), .adcData(adcData), .detCfg(detCfg), .refExternal(refExternal),
      .adcChan(adcChan), .adcStart(adcStart), .poLevel(poLevel), .poDriveEn(poDriveEn),
      .outOneWeakSink(outOneWeakSink));
   sss_adc_model adc (.core_clk(core_clk), .rstn(rstn), .adcStart(adcStart),
      .adcChan(adcChan), .adcDone(adcDone), .adcData(adcData));
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask : rd

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////
   task automatic t_undervoltage_lockout_level;
      step(8);
      check("dark level", 8'h00, poLevel);
      check("weak sink", 8'h01, {7'h00, outOneWeakSink});
      @(posedge core_clk);
      uvloOk <= 1'b1;
      step(8);
      check("sink off", 8'h00, {7'h00, outOneWeakSink});
      check("drive", 8'hff, poDriveEn);
      check("idle levels", 8'hff, poLevel);
      $display("test undervoltage_lockout_level done");
   endtask : t_undervoltage_lockout_level

   task automatic t_regs;
      logic [7:0] d;
      rd(8'hf0, d);
      check("unmapped", 8'h00, d);
      wr(sss_pkg::A_GLOBAL, 8'h01);
      rd(sss_pkg::A_GLOBAL, d);
      check("global", 8'h01, d);
      check("ref ext", 8'h01, {7'h00, refExternal});
      wr(sss_pkg::A_STATUS, 8'hff);
      rd(sss_pkg::A_STATUS, d);
      check("status ro", 8'h00, d);
      wr(sss_pkg::A_GLOBAL, 8'h00);
      wr(8'h60, 8'h7f);
      wr(8'h62, 8'h07);
      step(1);
      check("pri code", 8'h7f, detCfg[0].priCode);
      check("range bits", 8'h07, {5'h00, detCfg[0].neg, detCfg[0].secOver,
         detCfg[0].highRange});
      wr(8'h62, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_mr;
      logic [7:0] d;
      int k;
      wr(8'h02, 8'h40);
      wr(8'h04, 8'h08);
      step(4);
      check("out0 idle", 8'hfe, poLevel);
      @(posedge core_clk);
      manualResetN <= 1'b0;
      step(5);
      check("out0 forced", 8'hff, poLevel);
      @(posedge core_clk);
      manualResetN <= 1'b1;
      k = 0;
      while (poLevel[0] !== 1'b0 && k < 40) begin
         step(1);
         k++;
      end
      // Sync, one to two ticks of delay and the output register.
      check("release delay", 8'h01, 8'(k >= 6 && k <= 16));
      rd(8'h48, d);
      check("fault mr", 8'h04, d);
      rd(8'h48, d);
      check("fault sticky", 8'h04, d);
      wr(8'h48, 8'h04);
      rd(8'h48, d);
      check("fault clear", 8'h00, d);
      $display("test manual reset done");
   endtask : t_mr

   task automatic t_margin;
      logic [7:0] d;
      @(posedge core_clk);
      marginN <= 1'b0;
      repeat (3) @(posedge core_clk);
      manualResetN <= 1'b0;
      step(8);
      check("margin beats mr", 8'hfe, poLevel);
      @(posedge core_clk);
      manualResetN <= 1'b1;
      repeat (4) @(posedge core_clk);
      marginN <= 1'b1;
      step(30);
      check("after margin", 8'hfe, poLevel);
      rd(8'h48, d);
      check("no fault in margin", 8'h00, d);
      $display("test margin done");
   endtask : t_margin

   task automatic t_adc;
      logic [7:0] d;
      logic [9:0] s;
      step(400);
      for (int c = 0; c < 8; c++) begin
         s = {~3'(c), 3'(c), 4'h5};
         rd(8'h50 + 8'(2 * c), d);
         check("adc high", s[9:2], d);
         rd(8'h51 + 8'(2 * c), d);
         check("adc low", {s[1:0], 6'h00}, d);
      end
      check("levels untouched", 8'hfe, poLevel);
      $display("test scan done");
   endtask : t_adc

   task automatic t_det;
      logic [7:0] d;
      wr(8'h10, 8'h01);
      wr(8'h14, 8'h08);
      @(posedge core_clk);
      detPriTrip <= 6'h01;
      step(5);
      rd(8'h4a, d);
      check("uv fault", 8'h01, d);
      check("out2 asserted", 8'h04, poLevel & 8'h04);
      @(posedge core_clk);
      detPriTrip <= 6'h00;
      $display("test detector done");
   endtask : t_det

   task automatic t_wd;
      logic [7:0] d;
      // Normal period select 0 is 500 ticks, so 2000 cycles at four cycles a tick.
      wr(8'h0a, 8'h10);
      wr(8'h43, 8'h80);
      wr(8'h42, 8'h80);
      step(1900);
      rd(8'h49, d);
      check("wd early", 8'h00, d);
      @(posedge core_clk);
      gpiPin <= 4'h1;
      step(1900);
      rd(8'h49, d);
      check("wd cleared", 8'h00, d);
      step(200);
      rd(8'h49, d);
      check("wd timeout", 8'h10, d);
      $display("test watchdog done");
   endtask : t_wd
   ////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 8000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      t_undervoltage_lockout_level();
      t_regs();
      t_mr();
      t_margin();
      t_adc();
      t_det();
      t_wd();
      test_done();
   end
endmodule : sss_supervisor_tb_top

bind sss_supervisor sss_supervisor_checker chk (.core_clk(core_clk), .rstn(rstn),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .uvloOk(uvloOk), .refExternal(refExternal), .adcChan(adcChan),
   .adcStart(adcStart), .poLevel(poLevel), .poDriveEn(poDriveEn),
   .outOneWeakSink(outOneWeakSink));
